// ### verilog/leil_pkg.sv
package leil_pkg;

    // Register byte offsets (register window of one channel)
    localparam logic [7:0] leil_latch_off = 8'h00;
    localparam logic [7:0] leil_edge_off = 8'h04;
    localparam logic [7:0] leil_live_off = 8'h08;

    // Bit positions inside the latch, edge-select and live-status words
    localparam int leil_bit_line_los = 0;
    localparam int leil_bit_second_los = 1;
    localparam int leil_bit_tx_los = 2;
    localparam int leil_bit_tx_clk = 3;
    localparam int leil_bit_drv_fault = 4;
    localparam int leil_bit_rx_jitter = 5;

    localparam int leil_num_events = 6;
    localparam logic [7:0] leil_latch_reset = 8'h00;
    localparam logic [7:0] leil_edge_reset = 8'h00;

    localparam logic [1:0] leil_resp_okay = 2'h0;
    localparam logic [1:0] leil_resp_slverr = 2'h2;

    // Live event inputs travel together
    typedef struct packed {
        logic rx_jitter_buffer;
        logic driver_fault;
        logic tx_clock_missing;
        logic tx_signal_loss;
        logic second_signal_loss;
        logic line_signal_loss;
    } leil_live_t;

endpackage

// ### verilog/leil_edge_latch.sv
`timescale 1ns/1ps
`default_nettype none
module leil_edge_latch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic live,
    input wire logic any_edge,
    input wire logic clear,
    output logic latch
);
    logic prev_q;
    logic prev_d;
    logic latch_q;
    logic latch_d;
    logic hit;

    always_comb begin
        prev_d = live;
        hit = any_edge ? (live ^ prev_q) : (live & ~prev_q);
        // Set wins over a coincident clear so no event is lost
        latch_d = hit | (latch_q & ~clear);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            latch_q <= latch_d;
        end
    end

    assign latch = latch_q;
endmodule
`default_nettype wire

// ### verilog/leil_top.sv
// Behaviour
// - With driver-fault edge select at zero, a rising live driver-fault status sets its latch.
// - With driver-fault edge select at one, any change of the live driver-fault status sets it.
// - Latches reset to zero, and software clears a latch by writing one to it.
// - Every set latch drives the shared active-low interrupt output while it stays set.
// - With tx-clock-missing edge select at zero, a rising live status sets its latch.
// - With tx-clock-missing edge select at one, any change of the live status sets its latch.
// - Tx signal-loss latch sets on a rising live change at select zero, any change at one.
// - With signal-loss edge select at zero, a rising second-loss status sets its latch.
// - With signal-loss edge select at one, any change of second-loss status sets its latch.
// - A receive jitter buffer over or underflow sets its latch, reported on the interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module leil_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire leil_pkg::leil_live_t live_status,
    input wire logic rx_jitter_buffer_fault,
    output logic irq_n
);
    // Write channel state
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic w_lane0_q, w_lane0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    // Read channel state
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    // Control register
    logic [7:0] edge_q, edge_d;
    logic [7:0] clear_mask;
    logic [7:0] latch_word;
    logic [7:0] live_word;
    logic do_write;
    logic [leil_pkg::leil_num_events-1:0] live_vec;
    logic [leil_pkg::leil_num_events-1:0] any_edge_vec;
    logic [leil_pkg::leil_num_events-1:0] latch_vec;

    // Second-loss and line-loss share one signal-loss edge select
    always_comb begin
        live_vec = '0;
        live_vec[leil_pkg::leil_bit_line_los] = live_status.line_signal_loss;
        live_vec[leil_pkg::leil_bit_second_los] = live_status.second_signal_loss;
        live_vec[leil_pkg::leil_bit_tx_los] = live_status.tx_signal_loss;
        live_vec[leil_pkg::leil_bit_tx_clk] = live_status.tx_clock_missing;
        live_vec[leil_pkg::leil_bit_drv_fault] = live_status.driver_fault;
        live_vec[leil_pkg::leil_bit_rx_jitter] = live_status.rx_jitter_buffer;
        any_edge_vec = edge_q[leil_pkg::leil_num_events-1:0];
        any_edge_vec[leil_pkg::leil_bit_line_los] = edge_q[leil_pkg::leil_bit_second_los];
    end

    // Jitter buffer event is a rising edge of the OR of both fault inputs
    // Its edge select bit is ignored: this latch is rising-edge only
    logic rx_jitter_live;
    assign rx_jitter_live = live_status.rx_jitter_buffer | rx_jitter_buffer_fault;

    genvar gi;
    generate
        for (gi = 0; gi < leil_pkg::leil_num_events; gi++) begin : g_lat
            if (gi == leil_pkg::leil_bit_rx_jitter) begin : g_rja
                leil_edge_latch u_lat (
                    .aclk(aclk),
                    .aresetn(aresetn),
                    .live(rx_jitter_live),
                    .any_edge(1'b0),
                    .clear(clear_mask[gi]),
                    .latch(latch_vec[gi])
                );
            end else begin : g_std
                leil_edge_latch u_lat (
                    .aclk(aclk),
                    .aresetn(aresetn),
                    .live(live_vec[gi]),
                    .any_edge(any_edge_vec[gi]),
                    .clear(clear_mask[gi]),
                    .latch(latch_vec[gi])
                );
            end
        end
    endgenerate

    always_comb begin
        latch_word = 8'h00;
        latch_word[leil_pkg::leil_num_events-1:0] = latch_vec;
        live_word = 8'h00;
        live_word[leil_pkg::leil_num_events-1:0] = live_vec;
    end

    // Combinational so the pin falls in the same cycle as the latch sets
    assign irq_n = ~(|latch_vec);

    // Write path: address and data accepted in either order
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_lane0_d = w_lane0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        edge_d = edge_q;
        clear_mask = 8'h00;
        do_write = aw_have_q && w_have_q && !bvalid_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_lane0_d = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = leil_pkg::leil_resp_okay;
            if (aw_addr_q == leil_pkg::leil_latch_off) begin
                if (w_lane0_q) begin
                    clear_mask = w_data_q[7:0];
                end
            end else if (aw_addr_q == leil_pkg::leil_edge_off) begin
                if (w_lane0_q) begin
                    edge_d = w_data_q[7:0];
                end
            end else if (aw_addr_q == leil_pkg::leil_live_off) begin
                bresp_d = leil_pkg::leil_resp_okay;
            end else begin
                bresp_d = leil_pkg::leil_resp_slverr;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // Read path
    // Data is captured at the address handshake and held until taken
    // Only the low address byte is decoded; upper bits alias
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = leil_pkg::leil_resp_okay;
            if (s_axi_araddr[7:0] == leil_pkg::leil_latch_off) begin
                rdata_d = {24'h000000, latch_word};
            end else if (s_axi_araddr[7:0] == leil_pkg::leil_edge_off) begin
                rdata_d = {24'h000000, edge_q};
            end else if (s_axi_araddr[7:0] == leil_pkg::leil_live_off) begin
                rdata_d = {24'h000000, live_word};
            end else begin
                rdata_d = 32'h00000000;
                rresp_d = leil_pkg::leil_resp_slverr;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= leil_pkg::leil_resp_okay;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= leil_pkg::leil_resp_okay;
            edge_q <= leil_pkg::leil_edge_reset;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_lane0_q <= w_lane0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            edge_q <= edge_d;
        end
    end

    // One write and one read in flight; new ones wait for the response
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// ### testbench/leil_host.sv
`timescale 1ns/1ps
`default_nettype none
module leil_host (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {3{32'h5a5a_5a5a}};
        s_axi_wstrb = 4'hf;
    end
    // Released lines flip so a stale value never passes for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end while (!(s_axi_rvalid && s_axi_rready));
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### testbench/leil_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module leil_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire leil_pkg::leil_live_t live_status,
    input wire logic rx_jitter_buffer_fault,
    input wire logic irq_n
);
    logic [5:0] cur;
    logic [5:0] prev_d;
    logic [5:0] prev_q;
    assign cur = live_status | {rx_jitter_buffer_fault, 5'h00};
    // Mirrors the edge history, which also clears to zero in reset
    always_comb prev_d = aresetn ? cur : 6'h00;
    always_ff @(posedge aclk) prev_q <= prev_d;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    rise_sets_irq_a: assert property (|(cur & ~prev_q) |=> !irq_n)
        else $error("rising live input left irq_n high");
    quiet_holds_a: assert property (irq_n && cur == prev_q |=> irq_n)
        else $error("irq_n fell with no live change");
    clear_by_write_a: assert property ($rose(irq_n) |-> $rose(s_axi_bvalid))
        else $error("irq_n released without a write");
    write_resp_a: assert property (both_taken |=> resp_late)
        else $error("write response not two cycles after take");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stayed after handshake");
    busy_refuses_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> irq_n && !s_axi_bvalid)
        else $error("not idle after reset");
endmodule
bind leil_top leil_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .live_status, .rx_jitter_buffer_fault, .irq_n);
`default_nettype wire

// ### testbench/line_event_interrupt_latch_bench.sv
`timescale 1ns/1ps
`default_nettype none
module line_event_interrupt_latch_bench;
    localparam logic [7:0] lat_a = leil_pkg::leil_latch_off;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    leil_pkg::leil_live_t live_status = '0;
    logic rx_jitter_buffer_fault = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_n;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2.5 aclk = ~aclk;
    leil_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .live_status, .rx_jitter_buffer_fault, .irq_n);
    leil_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic see(input logic [7:0] e);
        host.rd(lat_a, q, r);
        chk(q, {24'h000000, e});
        chk({31'h00000000, irq_n}, {31'h00000000, e == 8'h00});
    endtask
    task automatic drive(input int b, input logic v);
        @(posedge aclk);
        if (b == leil_pkg::leil_bit_rx_jitter) rx_jitter_buffer_fault <= v;
        else live_status[b] <= v;
        repeat (2) @(posedge aclk);
    endtask
    task automatic t_reg;
        see(leil_pkg::leil_latch_reset);
        chk({30'h00000000, r}, {30'h00000000, leil_pkg::leil_resp_okay});
        host.rd(leil_pkg::leil_edge_off, q, r);
        chk(q, {24'h000000, leil_pkg::leil_edge_reset});
        host.rd(8'h0c, q, r);
        chk(q, 32'h00000000);
        chk({30'h00000000, r}, {30'h00000000, leil_pkg::leil_resp_slverr});
        host.wr(8'h0c, 8'hff, r);
        chk({30'h00000000, r}, {30'h00000000, leil_pkg::leil_resp_slverr});
        $display("reset and map test done");
    endtask
    task automatic t_edges(input logic any);
        logic [7:0] m;
        host.wr(leil_pkg::leil_edge_off, any ? 8'h1f : 8'h00, r);
        host.rd(leil_pkg::leil_edge_off, q, r);
        chk(q, any ? 32'h0000001f : 32'h00000000);
        for (int b = 0; b < leil_pkg::leil_num_events; b++) begin
            m = 8'h01 << b;
            drive(b, 1'b1);
            see(m);
            host.wr(lat_a, m, r);
            see(8'h00);
            drive(b, 1'b0);
            see((any && b < leil_pkg::leil_bit_rx_jitter) ? m : 8'h00);
            host.wr(lat_a, m, r);
        end
        $display("edge test done, any=%0d", any);
    endtask
    task automatic t_w1c;
        drive(leil_pkg::leil_bit_tx_los, 1'b1);
        drive(leil_pkg::leil_bit_drv_fault, 1'b1);
        host.rd(leil_pkg::leil_live_off, q, r);
        chk(q, 32'h00000014);
        host.wr(lat_a, 8'h00, r);
        see(8'h14);
        host.wr(lat_a, 8'h04, r);
        chk({30'h00000000, r}, {30'h00000000, leil_pkg::leil_resp_okay});
        see(8'h10);
        host.wr(lat_a, 8'h10, r);
        see(8'h00);
        @(posedge aclk);
        live_status.rx_jitter_buffer <= 1'b1;
        repeat (2) @(posedge aclk);
        see(8'h20);
        host.wr(lat_a, 8'h20, r);
        see(8'h00);
        live_status <= '0;
        $display("clear test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reg;
        t_edges(1'b0);
        t_w1c;
        t_edges(1'b1);
        print_verdict;
    end
    // Run needs under a thousand cycles; the ceiling leaves ample margin
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict;
        end
    end
endmodule
`default_nettype wire
